/* File: hdl/sfsf_select_framing.sv */
// Purpose: Chip-select framing front end of a serial flash device.
// Assumes: Host drives select, clock and data in SPI mode 0 or 3.
// Notes:   Pins are oversampled by the system clock.
`timescale 1ns/10ps
`default_nettype none
module sfsf_select_framing
   import sfsf_pkg::*;
#(
   parameter int unsigned BUSY_LEN   = BUSY_CYCLES,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_reset,
   input  wire logic                   i_sel_n,
   input  wire logic                   i_sck,
   input  wire logic                   i_sdi,
   input  wire logic                   i_alt_page,
   input  wire logic [7:0]             i_tx_byte,
   output logic                        o_sdo,
   output logic                        o_sdo_oe_n,
   output logic                        o_busy,
   output logic                        o_active,
   output logic [BYTE_ADDR_W-1:0]      o_page_bytes,
   output logic [8:0]                  o_rx_data,
   output logic                        o_rx_valid,
   input  wire logic                   i_rx_ready,
   output logic                        o_rx_overrun
);
   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   sfsf_pins_s pins_meta;
   sfsf_pins_s pins_sync;
   sfsf_pins_s pins_prev;

   // Two flops before any logic; third stage only for edge detection
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pins_meta <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         pins_sync <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0};
         pins_prev <= '{sel_n: 1'b1, sck: 1'b0, sdi: 1'b0};
      end else begin
         pins_meta <= '{sel_n: i_sel_n, sck: i_sck, sdi: i_sdi};
         pins_sync <= pins_meta;
         pins_prev <= pins_sync;
      end
   end

   logic selected;
   logic sel_fall;
   logic sel_rise;
   logic sck_rise;
   logic sck_fall;

   assign selected = !pins_sync.sel_n;
   assign sel_fall = pins_prev.sel_n && !pins_sync.sel_n;
   assign sel_rise = !pins_prev.sel_n && pins_sync.sel_n;
   // Edges count only inside a frame; mode 0 or 3 idle level is moot
   assign sck_rise = selected && !sel_fall &&
                     !pins_prev.sck && pins_sync.sck;
   assign sck_fall = selected && !sel_fall &&
                     pins_prev.sck && !pins_sync.sck;

   // -------------------------------------------------------------------
   // Framing state
   // -------------------------------------------------------------------
   sfsf_state_e              state;
   sfsf_state_e              next_state;
   logic [BUSY_CNT_W-1:0]    busy_cnt;
   logic [BUSY_CNT_W-1:0]    next_busy_cnt;
   logic                     launch;
   logic                     next_launch;
   logic [2:0]               bit_cnt;
   logic [2:0]               next_bit_cnt;
   logic [7:0]               shift_in;
   logic [7:0]               next_shift_in;
   logic                     first_byte;
   logic                     next_first_byte;
   logic [7:0]               shift_out;
   logic [7:0]               next_shift_out;
   logic                     sdo;
   logic                     next_sdo;
   logic                     byte_done;
   logic [7:0]               rx_byte;
   logic                     overrun;
   logic                     next_overrun;
   logic                     fifo_ready;

   assign rx_byte   = {shift_in[6:0], pins_sync.sdi};
   assign byte_done = sck_rise && (bit_cnt == 3'h7);

   // Frame, busy timer and serial shifters
   always_comb begin
      next_state      = state;
      next_busy_cnt   = busy_cnt;
      next_launch     = launch;
      next_bit_cnt    = bit_cnt;
      next_shift_in   = shift_in;
      next_first_byte = first_byte;
      next_shift_out  = shift_out;
      next_sdo        = sdo;
      next_overrun    = overrun;
      unique case (state)
         SFSF_STANDBY: begin
            if (sel_fall) begin
               next_state      = SFSF_ACTIVE;
               next_bit_cnt    = BIT_CNT_RST;
               next_first_byte = 1'b1;
               next_launch     = 1'b0;
               next_overrun    = 1'b0;
               next_shift_out  = i_tx_byte;
               next_sdo        = i_tx_byte[7];
            end
         end
         SFSF_ACTIVE: begin
            if (sck_rise) begin
               next_shift_in = rx_byte;
               next_bit_cnt  = bit_cnt + 3'h1;
            end
            if (byte_done) begin
               next_first_byte = 1'b0;
               if (first_byte &&
                   (rx_byte == OP_PROGRAM || rx_byte == OP_ERASE)) begin
                  next_launch = 1'b1;
               end
               if (!fifo_ready) begin
                  next_overrun = 1'b1;
               end
            end
            if (sck_fall) begin
               // Reload at byte boundary so output stays byte aligned
               if (bit_cnt == 3'h0) begin
                  next_shift_out = i_tx_byte;
               end else begin
                  next_shift_out = {shift_out[6:0], 1'b0};
               end
               next_sdo = next_shift_out[7];
            end
            if (sel_rise) begin
               if (launch) begin
                  next_state    = SFSF_BUSY;
                  next_busy_cnt = BUSY_CNT_W'(BUSY_LEN - 1);
               end else begin
                  next_state    = SFSF_STANDBY;
               end
            end
         end
         SFSF_BUSY: begin
            // Host clock plays no part here
            if (busy_cnt == '0) begin
               next_state = SFSF_STANDBY;
            end else begin
               next_busy_cnt = busy_cnt - BUSY_CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state      <= SFSF_STANDBY;
         busy_cnt   <= '0;
         launch     <= 1'b0;
         bit_cnt    <= BIT_CNT_RST;
         shift_in   <= 8'h00;
         first_byte <= 1'b1;
         shift_out  <= 8'h00;
         sdo        <= 1'b0;
         overrun    <= 1'b0;
      end else begin
         state      <= next_state;
         busy_cnt   <= next_busy_cnt;
         launch     <= next_launch;
         bit_cnt    <= next_bit_cnt;
         shift_in   <= next_shift_in;
         first_byte <= next_first_byte;
         shift_out  <= next_shift_out;
         sdo        <= next_sdo;
         overrun    <= next_overrun;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   // Tri-state whenever the host has deselected the part
   assign o_sdo        = sdo;
   assign o_sdo_oe_n   = !(state == SFSF_ACTIVE && selected);
   assign o_active     = (state == SFSF_ACTIVE);
   assign o_busy       = (state == SFSF_BUSY);
   assign o_rx_overrun = overrun;
   // Page size select; reported on o_page_bytes only, no page buffer
   assign o_page_bytes = i_alt_page ? BYTE_ADDR_W'(PAGE_ALT_BYTES)
                                    : BYTE_ADDR_W'(PAGE_STD_BYTES);

   // -------------------------------------------------------------------
   // Received byte buffer
   // -------------------------------------------------------------------
   sfsf_byte_s rx_word;
   logic       rx_push;
   assign rx_word = '{first: first_byte, data: rx_byte};
   // Only bytes framed by an active selection enter the buffer
   assign rx_push = byte_done && (state == SFSF_ACTIVE);

   sfsf_fifo #(
      .WIDTH ($bits(sfsf_byte_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_data    (rx_word),
      .i_valid   (rx_push),
      .o_ready   (fifo_ready),
      .o_data    (o_rx_data),
      .o_valid   (o_rx_valid),
      .i_ready   (i_rx_ready)
   );

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   desel_hiz_a: assert property (pins_sync.sel_n |-> o_sdo_oe_n)
      else $error("output driven while deselected");
   desel_norx_a: assert property (!selected |-> !rx_push)
      else $error("byte captured while deselected");
   frame_start_a: assert property ($rose(o_active) |-> $past(sel_fall))
      else $error("activation without select fall");
   new_frame_a: assert property (sel_fall && state == SFSF_STANDBY
         |=> bit_cnt == 3'h0 && first_byte)
      else $error("counters not cleared at selection");
   busy_hold_a: assert property (state == SFSF_ACTIVE && sel_rise && launch
         |=> o_busy && !o_active)
      else $error("self-timed cycle not held");
   busy_end_a: assert property (o_busy && busy_cnt == '0
         |=> !o_busy && !o_active)
      else $error("busy did not end at count zero");
   desel_count_a: assert property (!selected |=> $stable(bit_cnt))
      else $error("counter moved while deselected");
   cmd_only_sel_a: assert property (rx_push |-> $past(!pins_sync.sel_n))
      else $error("command accepted outside selection");
   sample_rise_a: assert property (sck_rise && state == SFSF_ACTIVE
         && !sel_rise |=> shift_in[0] == $past(pins_sync.sdi))
      else $error("input not sampled on rising edge");
   page_size_a: assert property (o_page_bytes == 9'h100
         || o_page_bytes == 9'h108)
      else $error("bad page size");

   byte_rx_c: cover property (rx_push);
   busy_cycle_c: cover property (o_busy ##1 !o_busy);
   overrun_c: cover property ($rose(o_rx_overrun));
endmodule : sfsf_select_framing
`default_nettype wire

/* File: hdl/sfsf_pkg.sv */
// Purpose: Shared constants and types for the serial flash select framing.
// Assumes: 100 MHz system clock samples all serial pins.
// Notes:   Page geometry and self-timed cycle length live here.
package sfsf_pkg;
   // -------------------------------------------------------------------
   // Geometry
   // -------------------------------------------------------------------
   localparam int unsigned PAGE_COUNT     = 1024;
   localparam int unsigned PAGE_STD_BYTES = 256;
   localparam int unsigned PAGE_ALT_BYTES = 264;
   localparam int unsigned PAGE_ADDR_W    = 10;
   localparam int unsigned BYTE_ADDR_W    = 9;
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned BUSY_TIME_US   = 100;
   localparam int unsigned BUSY_CYCLES    = BUSY_TIME_US * CLK_MHZ;
   localparam int unsigned BUSY_CNT_W     = 24;
   localparam logic [2:0]  BIT_CNT_RST    = 3'h0;
   // Command opcodes launching a self-timed cycle (arbitrary examples)
   localparam logic [7:0]  OP_PROGRAM     = 8'h82;
   localparam logic [7:0]  OP_ERASE       = 8'h81;

   // Serial pin bundle seen by the block
   typedef struct packed {
      logic sel_n;
      logic sck;
      logic sdi;
   } sfsf_pins_s;

   // Received byte with framing marker
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } sfsf_byte_s;

   typedef enum logic [1:0] {
      SFSF_STANDBY,
      SFSF_ACTIVE,
      SFSF_BUSY
   } sfsf_state_e;
endpackage : sfsf_pkg

/* File: hdl/sfsf_fifo.sv */
// Purpose: Valid/ready FIFO carrying received bytes to the core.
// Assumes: Single clock, synchronous reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/10ps
`default_nettype none
module sfsf_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // -------------------------------------------------------------------
   // Pointers
   // -------------------------------------------------------------------
   // Full when pointers differ only in the wrap bit
   assign o_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
                      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign o_valid = (wr_ptr != rd_ptr);
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;
   assign o_data  = mem[rd_ptr[AW-1:0]];

   always_comb begin
      next_wr_ptr = wr_ptr + (AW+1)'(push);
      next_rd_ptr = rd_ptr + (AW+1)'(pop);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage has no reset, only written on push
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_data;
      end
   end
endmodule : sfsf_fifo
`default_nettype wire

/* File: test/sfsf_host_model.sv */
// Purpose: Host SPI controller model driving select, clock and data.
// Assumes: Mode 0 or 3, clock half period of 8 reference clocks.
// Notes:   Data line toggles while deselected instead of holding.
`timescale 1ns/10ps
`default_nettype none
module sfsf_host_model (
   input  wire logic i_ref_clk,
   input  wire logic i_sdo,
   output var logic  o_sel_n,
   output var logic  o_sck,
   output var logic  o_sdi
);
   logic cpol  = 1'b0;
   logic noise = 1'b0;
   initial begin
      o_sel_n = 1'b1;
      o_sck   = 1'b0;
      o_sdi   = 1'b0;
   end
   // Deselected data line keeps moving, clock too when noise is set, so a stale value never looks valid
   always @(negedge i_ref_clk) begin
      if (o_sel_n) begin
         o_sdi <= ~o_sdi;
         if (noise) o_sck <= ~o_sck;
      end
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask : wait_clk
   // Clock parks at its idle level before the select fall
   task automatic select(input logic mode3);
      wait_clk(1);
      cpol = mode3;
      o_sck <= mode3;
      wait_clk(4);
      o_sel_n <= 1'b0;
      wait_clk(6);
   endtask : select
   // MSB first; data set while clock low, sampled at the rise
   task automatic xfer(input logic [7:0] tx, input int nb,
                       output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         o_sck <= 1'b0;
         o_sdi <= tx[i];
         wait_clk(8);
         o_sck <= 1'b1;
         rx[i] = i_sdo;
         wait_clk(8);
      end
      if (!cpol) o_sck <= 1'b0;
   endtask : xfer
   task automatic deselect();
      wait_clk(4);
      o_sel_n <= 1'b1;
      wait_clk(4);
   endtask : deselect
endmodule : sfsf_host_model
`default_nettype wire

/* File: test/sfsf_select_framing_tb_top.sv */
// Purpose: Self-checking bench for the select framing front end.
// Assumes: Inputs change on the falling clock edge only.
// Notes:   Busy length shortened to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module sfsf_select_framing_tb_top;
   import sfsf_pkg::*;
   localparam int unsigned BUSY_SIM = 20;
   localparam int          LIMIT    = 20000;
   logic       i_ref_clk  = 1'b0;
   logic       i_reset    = 1'b1;
   logic       i_alt_page = 1'b0;
   logic       i_rx_ready = 1'b0;
   logic [7:0] i_tx_byte  = 8'h00;
   logic       sel_n, sck, sdi, o_sdo, o_sdo_oe_n, o_busy, o_active;
   logic       o_rx_valid, o_rx_overrun;
   logic [8:0] o_page_bytes, o_rx_data;
   logic [7:0] rx;
   int         fails = 0, checks_done = 0, cycles = 0;

   sfsf_select_framing #(.BUSY_LEN(BUSY_SIM))
   u_sfsf_select_framing (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_sel_n(sel_n), .i_sck(sck), .i_sdi(sdi), .i_alt_page(i_alt_page),
      .i_tx_byte(i_tx_byte), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
      .o_busy(o_busy), .o_active(o_active), .o_page_bytes(o_page_bytes),
      .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
      .i_rx_ready(i_rx_ready), .o_rx_overrun(o_rx_overrun));
   sfsf_host_model u_sfsf_host_model (.i_ref_clk(i_ref_clk),
      .i_sdo(o_sdo), .o_sel_n(sel_n), .o_sck(sck), .o_sdi(sdi));

   initial forever #5 i_ref_clk = ~i_ref_clk;
   // Hang guard: a stuck wait still ends in the verdict
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // Bounded wait for a byte, compare, then one-cycle pop
   task automatic pop(input logic [8:0] exp);
      int n;
      n = 0;
      while (o_rx_valid !== 1'b1 && n < 60) begin
         @(negedge i_ref_clk);
         n++;
      end
      `CHK(o_rx_data, exp)
      i_rx_ready <= 1'b1;
      @(negedge i_ref_clk);
      i_rx_ready <= 1'b0;
      @(negedge i_ref_clk);
   endtask : pop
   task automatic t_geometry();
      `CHK(o_sdo_oe_n, 1'b1)
      `CHK(o_active, 1'b0)
      `CHK(o_page_bytes, 9'(PAGE_STD_BYTES))
      i_alt_page <= 1'b1;
      @(negedge i_ref_clk);
      `CHK(o_page_bytes, 9'(PAGE_ALT_BYTES))
      i_alt_page <= 1'b0;
   endtask : t_geometry
   // Two whole bytes in mode 0 with readback of the shifted byte
   task automatic t_frame();
      i_tx_byte <= 8'hc3;
      u_sfsf_host_model.select(1'b0);
      `CHK(o_active, 1'b1)
      `CHK(o_sdo_oe_n, 1'b0)
      u_sfsf_host_model.xfer(8'ha5, 8, rx);
      `CHK(rx, 8'hc3)
      u_sfsf_host_model.xfer(8'h3c, 8, rx);
      u_sfsf_host_model.deselect();
      `CHK(o_active, 1'b0)
      `CHK(o_sdo_oe_n, 1'b1)
      pop(9'h1a5);
      pop(9'h03c);
   endtask : t_frame
   // Idle noise, then a partial byte that must not leak into a new frame
   task automatic t_noise();
      u_sfsf_host_model.noise = 1'b1;
      repeat (200) @(negedge i_ref_clk);
      u_sfsf_host_model.noise = 1'b0;
      `CHK(o_rx_valid, 1'b0)
      `CHK(o_active, 1'b0)
      u_sfsf_host_model.select(1'b1);
      u_sfsf_host_model.xfer(8'hff, 4, rx);
      u_sfsf_host_model.deselect();
      u_sfsf_host_model.select(1'b1);
      u_sfsf_host_model.xfer(8'h5a, 8, rx);
      u_sfsf_host_model.deselect();
      pop(9'h15a);
      `CHK(o_rx_valid, 1'b0)
   endtask : t_noise
   // Both launch opcodes keep the device busy past the select rise
   task automatic t_busy();
      logic [7:0] ops [2];
      ops = '{OP_PROGRAM, OP_ERASE};
      foreach (ops[k]) begin
         i_tx_byte <= ops[k];
         u_sfsf_host_model.select(1'b0);
         u_sfsf_host_model.xfer(ops[k], 8, rx);
         u_sfsf_host_model.deselect();
         `CHK(o_busy, 1'b1)
         `CHK(o_sdo_oe_n, 1'b1)
         repeat (BUSY_SIM - 6) @(negedge i_ref_clk);
         `CHK(o_busy, 1'b1)
         repeat (12) @(negedge i_ref_clk);
         `CHK(o_busy, 1'b0)
         pop({1'b1, ops[k]});
      end
   endtask : t_busy
   // Overfill the FIFO with the consumer stalled, then drain it
   task automatic t_overrun();
      u_sfsf_host_model.select(1'b0);
      for (int i = 0; i < 17; i++) u_sfsf_host_model.xfer(8'(i), 8, rx);
      u_sfsf_host_model.deselect();
      `CHK(o_rx_overrun, 1'b1)
      for (int i = 0; i < 16; i++) pop({i == 0, 8'(i)});
      `CHK(o_rx_valid, 1'b0)
      u_sfsf_host_model.select(1'b0);
      `CHK(o_rx_overrun, 1'b0)
      u_sfsf_host_model.deselect();
   endtask : t_overrun
   initial begin
      repeat (4) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_reset <= 1'b0;
      @(negedge i_ref_clk);
      t_geometry();
      t_frame();
      t_noise();
      t_busy();
      t_overrun();
      close_out();
   end
endmodule : sfsf_select_framing_tb_top
`default_nettype wire
